// >>> logic/ooa_defines.vh
`ifndef OOA_DEFINES_VH
`define OOA_DEFINES_VH

// Register byte addresses
`define OOA_REG_CTRL       8'h00
`define OOA_REG_OPTIONS    8'h04
`define OOA_REG_NODE_LO    8'h08
`define OOA_REG_NODE_HI    8'h0C
`define OOA_REG_GROUP      8'h10
`define OOA_REG_FUNC       8'h14
`define OOA_REG_RXLIST     8'h18
`define OOA_REG_STATUS     8'h1C
`define OOA_REG_STATION_LO 8'h20
`define OOA_REG_STATION_HI 8'h24
`define OOA_REG_ACTIVE     8'h28
`define OOA_REG_IRQ_STS    8'h2C
`define OOA_REG_IRQ_MASK   8'h30

// Control bits
`define OOA_CTRL_OPEN      0
`define OOA_CTRL_CLOSE     1

// Open option bit positions
`define OOA_OPT_FRAME_HOLD 6
`define OOA_OPT_CONTENDER  7
`define OOA_OPT_PASS_BCN   8
`define OOA_OPT_RSVD_MASK  16'hFE00

// Completion status bits
`define OOA_STS_OPEN       0
`define OOA_STS_NODE_ERR   1
`define OOA_STS_LIST_ERR   2

// Interrupt bits
`define OOA_IRQ_OPEN_DONE  0
`define OOA_IRQ_BEACON     1
`define OOA_IRQ_WIDTH      2

// Receive list sizes in bytes
`define OOA_LIST_14        16'h000E
`define OOA_LIST_20        16'h0014
`define OOA_LIST_26        16'h001A
`define OOA_LIST_DEFAULT   16'h001A

// Address field masks
`define OOA_NODE_FMT_MASK  8'hC0
`define OOA_NODE_FMT_VAL   8'h40
`define OOA_GROUP_CMP_MASK 32'h7FFFFFFF
`define OOA_FUNC_CMP_MASK  32'h7FFFFFFC

// Bus responses
`define OOA_RESP_OKAY      2'h0
`define OOA_RESP_SLVERR    2'h2

`endif

// >>> logic/ooa_open_config.v
// Notes on behaviour
// - Frame hold set: start DMA only after a whole frame is copied.
// - Frame hold clear: start DMA each time an internal buffer fills.
// - Contender set: join contention that another station starts.
// - Contender bit ignored when this station starts contention itself.
// - Pass-beacon set: forward received beacon frames as receive data.
// - Forward next beacon only if source or type subvector changed.
// - Station address from node field; all zeros uses factory address.
// - Nonzero node address needs first byte bits 0,1 equal 01.
// - Accept frames to group address, bit 0 ignored in compare.
// - Group address of zero turns group recognition off.
// - Functional mask accepts frames, bits 0, 30 and 31 ignored.
// - Functional address of zero disables functional reception.
// - Receive list size is 0, 14, 20 or 26 bytes per fetch.
// - Receive list size zero means a 26-byte fetch.
// - Status bit 1 flags bad node address or all-zero factory address.
// - Status bit 2 flags a receive list size outside the legal set.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "ooa_defines.vh"

module ooa_open_config #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Factory station address
    input wire [47:0] factory_station_address,
    // Receive path events
    input wire rx_buf_full,
    input wire rx_frame_done,
    output reg rx_dma_start,
    output reg [15:0] rx_list_bytes,
    // Monitor contention
    input wire remote_contention_start,
    input wire local_contention_start,
    output reg contention_join,
    // Beacon frames
    input wire beacon_valid,
    input wire [47:0] beacon_src,
    input wire [7:0] beacon_type,
    output reg beacon_pass,
    // Destination address recognition
    input wire dest_valid,
    input wire [31:0] dest_addr,
    output reg group_hit,
    output reg func_hit,
    // Station state
    output reg [47:0] station_addr,
    output reg station_open,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions

function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
        merge_bytes = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    end
endfunction

function list_size_ok;
    input [15:0] size;
    begin
        list_size_ok = (size == 16'h0000) || (size == `OOA_LIST_14) ||
            (size == `OOA_LIST_20) || (size == `OOA_LIST_26);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Parameter staging registers written by software before open, then status and interrupt registers

reg [15:0] opt_q;
reg [47:0] node_q;
reg [31:0] group_q;
reg [31:0] func_q;
reg [15:0] rxlist_q;
reg [7:0] status_q;
reg [`OOA_IRQ_WIDTH-1:0] irq_sts_q;
reg [`OOA_IRQ_WIDTH-1:0] irq_mask_q;

// Values in force while open
reg [15:0] act_opt_q;
reg [31:0] act_group_q;
reg [31:0] act_func_q;

// Write channel state
reg [ADDR_W-1:0] wr_addr_q;
reg [31:0] wr_data_q;
reg [3:0] wr_strb_q;

wire [31:0] opt_mrg = merge_bytes({16'h0000, opt_q}, wr_data_q, wr_strb_q);
wire [31:0] node_hi_mrg =
    merge_bytes({16'h0000, node_q[15:0]}, wr_data_q, wr_strb_q);
wire [31:0] rxlist_mrg =
    merge_bytes({16'h0000, rxlist_q}, wr_data_q, wr_strb_q);

wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
wire rd_fire = s_axi_arvalid && s_axi_arready;

wire ctrl_wr = wr_fire && (wr_addr_q == `OOA_REG_CTRL) && wr_strb_q[0];
wire open_cmd = ctrl_wr && wr_data_q[`OOA_CTRL_OPEN] && !station_open;
wire close_cmd = ctrl_wr && wr_data_q[`OOA_CTRL_CLOSE] && station_open;

////////////////////////////////////////////////////////////////////////////////
// Open command validation

wire node_zero = (node_q == 48'h000000000000);
wire node_fmt_ok =
    (node_q[47:40] & `OOA_NODE_FMT_MASK) == `OOA_NODE_FMT_VAL;
wire factory_zero = (factory_station_address == 48'h000000000000);
wire node_err = node_zero ? factory_zero : !node_fmt_ok;
wire list_err = !list_size_ok(rxlist_q);
wire open_ok = !node_err && !list_err;

reg [7:0] status_d;
always @* begin
    status_d = 8'h00;
    status_d[`OOA_STS_OPEN] = open_ok;
    status_d[`OOA_STS_NODE_ERR] = node_err;
    status_d[`OOA_STS_LIST_ERR] = list_err;
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshakes: address and data taken in either order

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `OOA_RESP_OKAY;
        wr_addr_q <= {ADDR_W{1'b0}};
        wr_data_q <= 32'h00000000;
        wr_strb_q <= 4'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data_q <= s_axi_wdata;
            wr_strb_q <= s_axi_wstrb;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (wr_addr_q)
                `OOA_REG_CTRL, `OOA_REG_OPTIONS, `OOA_REG_NODE_LO,
                `OOA_REG_NODE_HI, `OOA_REG_GROUP, `OOA_REG_FUNC,
                `OOA_REG_RXLIST, `OOA_REG_IRQ_MASK:
                    s_axi_bresp <= `OOA_RESP_OKAY;
                default:
                    s_axi_bresp <= `OOA_RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Writable registers

always @(posedge aclk) begin
    if (!aresetn) begin
        opt_q <= 16'h0000;
        node_q <= 48'h000000000000;
        group_q <= 32'h00000000;
        func_q <= 32'h00000000;
        rxlist_q <= 16'h0000;
        irq_mask_q <= {`OOA_IRQ_WIDTH{1'b0}};
    end else if (wr_fire) begin
        case (wr_addr_q)
            // Reserved option bits are not stored; host leaves them zero
            `OOA_REG_OPTIONS:
                opt_q <= opt_mrg[15:0] & ~`OOA_OPT_RSVD_MASK;
            `OOA_REG_NODE_LO:
                node_q[47:16] <= merge_bytes(node_q[47:16], wr_data_q,
                    wr_strb_q);
            `OOA_REG_NODE_HI:
                node_q[15:0] <= node_hi_mrg[15:0];
            `OOA_REG_GROUP:
                group_q <= merge_bytes(group_q, wr_data_q, wr_strb_q);
            `OOA_REG_FUNC:
                func_q <= merge_bytes(func_q, wr_data_q, wr_strb_q);
            `OOA_REG_RXLIST:
                rxlist_q <= rxlist_mrg[15:0];
            `OOA_REG_IRQ_MASK:
                irq_mask_q <= wr_data_q[`OOA_IRQ_WIDTH-1:0];
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Open and close; staging writes while open do not disturb the live copy

always @(posedge aclk) begin
    if (!aresetn) begin
        station_open <= 1'b0;
        status_q <= 8'h00;
        act_opt_q <= 16'h0000;
        act_group_q <= 32'h00000000;
        act_func_q <= 32'h00000000;
        station_addr <= 48'h000000000000;
        rx_list_bytes <= `OOA_LIST_DEFAULT;
    end else if (open_cmd) begin
        status_q <= status_d;
        if (open_ok) begin
            station_open <= 1'b1;
            act_opt_q <= opt_q;
            act_group_q <= group_q;
            act_func_q <= func_q;
            station_addr <= node_zero ? factory_station_address
                : node_q;
            rx_list_bytes <= (rxlist_q == 16'h0000) ? `OOA_LIST_DEFAULT
                : rxlist_q;
        end
    end else if (close_cmd) begin
        station_open <= 1'b0;
        status_q <= 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Receive path, contention and address recognition

wire opt_hold = act_opt_q[`OOA_OPT_FRAME_HOLD];
wire opt_contend = act_opt_q[`OOA_OPT_CONTENDER];
wire opt_beacon = act_opt_q[`OOA_OPT_PASS_BCN];

reg [47:0] last_bcn_src_q;
reg [7:0] last_bcn_type_q;
reg last_bcn_vld_q;

wire bcn_new = !last_bcn_vld_q || (beacon_src != last_bcn_src_q) ||
    (beacon_type != last_bcn_type_q);
wire bcn_fwd = station_open && opt_beacon && beacon_valid && bcn_new;

always @(posedge aclk) begin
    if (!aresetn) begin
        rx_dma_start <= 1'b0;
        contention_join <= 1'b0;
        beacon_pass <= 1'b0;
        group_hit <= 1'b0;
        func_hit <= 1'b0;
        last_bcn_src_q <= 48'h000000000000;
        last_bcn_type_q <= 8'h00;
        last_bcn_vld_q <= 1'b0;
    end else begin
        // Hold mode trades latency for a whole frame per transfer
        rx_dma_start <= station_open &&
            (opt_hold ? rx_frame_done : rx_buf_full);
        // Own detection always contends, so the option is not consulted
        contention_join <= station_open && (local_contention_start ||
            (remote_contention_start && opt_contend));
        beacon_pass <= bcn_fwd;
        if (open_cmd) begin
            last_bcn_vld_q <= 1'b0;
        end else if (bcn_fwd) begin
            last_bcn_vld_q <= 1'b1;
            last_bcn_src_q <= beacon_src;
            last_bcn_type_q <= beacon_type;
        end
        group_hit <= station_open && dest_valid &&
            (act_group_q != 32'h00000000) &&
            ((dest_addr & `OOA_GROUP_CMP_MASK) ==
             (act_group_q & `OOA_GROUP_CMP_MASK));
        func_hit <= station_open && dest_valid &&
            (act_func_q != 32'h00000000) &&
            ((dest_addr & act_func_q & `OOA_FUNC_CMP_MASK) !=
             32'h00000000);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts: sticky, cleared by reading, a new event wins over the clear

wire [`OOA_IRQ_WIDTH-1:0] irq_evt = {bcn_fwd, open_cmd};
wire irq_rd_clr = rd_fire && (s_axi_araddr == `OOA_REG_IRQ_STS);
wire [`OOA_IRQ_WIDTH-1:0] irq_sts_d =
    (irq_rd_clr ? {`OOA_IRQ_WIDTH{1'b0}} : irq_sts_q) | irq_evt;

always @(posedge aclk) begin
    if (!aresetn) begin
        irq_sts_q <= {`OOA_IRQ_WIDTH{1'b0}};
        irq <= 1'b0;
    end else begin
        irq_sts_q <= irq_sts_d;
        irq <= |(irq_sts_d & irq_mask_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel

reg [31:0] rd_data;
reg rd_err;
always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
        `OOA_REG_CTRL: rd_data = {31'h00000000, station_open};
        `OOA_REG_OPTIONS: rd_data = {16'h0000, opt_q};
        `OOA_REG_NODE_LO: rd_data = node_q[47:16];
        `OOA_REG_NODE_HI: rd_data = {16'h0000, node_q[15:0]};
        `OOA_REG_GROUP: rd_data = group_q;
        `OOA_REG_FUNC: rd_data = func_q;
        `OOA_REG_RXLIST: rd_data = {16'h0000, rxlist_q};
        `OOA_REG_STATUS: rd_data = {24'h000000, status_q};
        `OOA_REG_STATION_LO: rd_data = station_addr[47:16];
        `OOA_REG_STATION_HI: rd_data = {16'h0000, station_addr[15:0]};
        `OOA_REG_ACTIVE: rd_data = {rx_list_bytes, act_opt_q};
        `OOA_REG_IRQ_STS:
            rd_data = {{(32-`OOA_IRQ_WIDTH){1'b0}}, irq_sts_q};
        `OOA_REG_IRQ_MASK:
            rd_data = {{(32-`OOA_IRQ_WIDTH){1'b0}}, irq_mask_q};
        default: rd_err = 1'b1;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `OOA_RESP_OKAY;
    end else if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `OOA_RESP_SLVERR : `OOA_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule

// >>> bench/ooa_open_config_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module ooa_open_config_props (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Ring side and station state
    input wire rx_buf_full,
    input wire rx_frame_done,
    input wire rx_dma_start,
    input wire [15:0] rx_list_bytes,
    input wire local_contention_start,
    input wire contention_join,
    input wire beacon_valid,
    input wire beacon_pass,
    input wire dest_valid,
    input wire group_hit,
    input wire [47:0] station_addr,
    input wire station_open
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_local;
        local_contention_start && station_open;
    endsequence
    sequence s_held;
        station_open ##1 station_open;
    endsequence

    property p_local_join;
        s_local |=> contention_join;
    endproperty
    a_local_join: assert property (p_local_join)
        else $error("no join");
    property p_join_open;
        contention_join |-> $past(station_open);
    endproperty
    a_join_open: assert property (p_join_open)
        else $error("join shut");
    property p_dma_cause;
        rx_dma_start |-> $past(station_open)
            && ($past(rx_frame_done) || $past(rx_buf_full));
    endproperty
    a_dma_cause: assert property (p_dma_cause)
        else $error("stray dma");
    property p_beacon;
        beacon_pass |-> $past(beacon_valid) && $past(station_open);
    endproperty
    a_beacon: assert property (p_beacon) else $error("stray beacon");
    property p_group;
        group_hit |-> $past(dest_valid) && $past(station_open);
    endproperty
    a_group: assert property (p_group) else $error("stray group hit");
    property p_list;
        rx_list_bytes inside {16'h000E, 16'h0014, 16'h001A};
    endproperty
    a_list: assert property (p_list) else $error("bad list size");
    property p_cfg_held;
        s_held |-> $stable(station_addr) && $stable(rx_list_bytes);
    endproperty
    a_cfg_held: assert property (p_cfg_held) else $error("cfg moved");
    property p_addr_set;
        station_open |-> station_addr != 48'h0;
    endproperty
    a_addr_set: assert property (p_addr_set) else $error("zero addr");
endmodule

bind ooa_open_config ooa_open_config_props u_props (
    .aclk, .aresetn, .rx_buf_full, .rx_frame_done, .rx_dma_start,
    .rx_list_bytes, .local_contention_start, .contention_join,
    .beacon_valid, .beacon_pass, .dest_valid, .group_hit,
    .station_addr, .station_open
);

// >>> bench/ooa_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module ooa_host_model (
    // Clock
    input wire aclk,
    // Write channels
    output logic [7:0] s_axi_awaddr = 8'h00,
    output logic s_axi_awvalid = 1'b0,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'hF,
    output logic s_axi_wvalid = 1'b0,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    // Read channels
    output logic [7:0] s_axi_araddr = 8'h00,
    output logic s_axi_arvalid = 1'b0,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    // Waits end only on the answer; the bench watchdog catches a stuck slave
    task wr(input [7:0] a, input [31:0] v, output [1:0] r);
        begin
            r = 2'hX;
            @(posedge aclk);
            s_axi_awaddr <= a;
            // Reserved option bits always go out as zero
            s_axi_wdata <= (a == 8'h04) ? (v & 32'h000001FF) : v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            forever begin
                @(posedge aclk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) begin
                    r = s_axi_bresp;
                    break;
                end
            end
            s_axi_bready <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, output [31:0] v, output [1:0] r);
        begin
            v = 32'hX;
            r = 2'hX;
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            forever begin
                @(posedge aclk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) begin
                    v = s_axi_rdata;
                    r = s_axi_rresp;
                    break;
                end
            end
            s_axi_rready <= 1'b0;
        end
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
`include "ooa_defines.vh"
////////////////////////////////////////////////////////////////
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, station_open, irq;
    logic [47:0] factory_station_address = 48'h0;
    logic [47:0] beacon_src = 48'h0;
    logic [47:0] station_addr;
    logic [31:0] dest_addr = 32'h0;
    logic [15:0] rx_list_bytes;
    logic [7:0] beacon_type = 8'h01;
    logic [5:0] evq = 6'h00;
    logic rx_dma_start, contention_join, beacon_pass, group_hit, func_hit;
    integer errors = 0;
    integer compares = 0;

    always #2.5 aclk = ~aclk;

    ooa_host_model h (.*);
    ooa_open_config dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
        .rx_buf_full(evq[0]), .rx_frame_done(evq[1]),
        .remote_contention_start(evq[2]), .local_contention_start(evq[3]),
        .beacon_valid(evq[4]), .dest_valid(evq[5]));
    ////////////////////////////////////////////////////////////////
    task chk(input [47:0] got, input [47:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            $display("errors %0d compares %0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task w(input [7:0] a, input [31:0] v);
        begin
            h.wr(a, v, r);
            chk(r, `OOA_RESP_OKAY);
        end
    endtask

    task rd(input [7:0] a, input [31:0] x);
        begin
            h.rd(a, d, r);
            chk(d, x);
            chk(r, `OOA_RESP_OKAY);
        end
    endtask

    // One-cycle ring pulse; outputs {func,group,beacon,join,dma}
    task ev(input [5:0] e, input [4:0] x);
        begin
            @(posedge aclk);
            evq <= e;
            @(posedge aclk);
            evq <= 6'h00;
            #1 chk({func_hit, group_hit, beacon_pass, contention_join,
                rx_dma_start}, x);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        errors = errors + 1;
        give_verdict;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk(rx_list_bytes, 16'h001A);
        h.rd(8'h40, d, r);
        chk(r, `OOA_RESP_SLVERR);
        chk(d, 32'h0);
        h.wr(`OOA_REG_STATUS, 32'h1, r);
        chk(r, `OOA_RESP_SLVERR);
        w(`OOA_REG_IRQ_MASK, 32'h3);
        w(`OOA_REG_NODE_LO, 32'hC0000001);
        w(`OOA_REG_RXLIST, 32'h7);
        w(`OOA_REG_CTRL, 32'h1);
        rd(`OOA_REG_STATUS, 32'h6);
        w(`OOA_REG_NODE_LO, 32'h0);
        w(`OOA_REG_RXLIST, 32'h0);
        w(`OOA_REG_CTRL, 32'h1);
        rd(`OOA_REG_STATUS, 32'h2);
        chk(station_open, 1'b0);
        factory_station_address <= 48'h400102030405;
        w(`OOA_REG_OPTIONS, 32'h0140);
        w(`OOA_REG_GROUP, 32'h00001234);
        w(`OOA_REG_FUNC, 32'h80000103);
        w(`OOA_REG_CTRL, 32'h1);
        rd(`OOA_REG_STATUS, 32'h1);
        chk(station_addr, 48'h400102030405);
        chk(rx_list_bytes, 16'h001A);
        rd(`OOA_REG_IRQ_STS, 32'h1);
        #1 chk(irq, 1'b0);
        ev(6'h01, 5'h00);
        ev(6'h02, 5'h01);
        ev(6'h04, 5'h00);
        ev(6'h08, 5'h02);
        ev(6'h10, 5'h04);
        ev(6'h10, 5'h00);
        @(posedge aclk) beacon_type <= 8'h02;
        ev(6'h10, 5'h04);
        ev(6'h10, 5'h00);
        @(posedge aclk) beacon_src <= 48'h400000000001;
        ev(6'h10, 5'h04);
        #1 chk(irq, 1'b1);
        rd(`OOA_REG_IRQ_STS, 32'h2);
        dest_addr <= 32'h80001234;
        ev(6'h20, 5'h08);
        @(posedge aclk) dest_addr <= 32'h80000003;
        ev(6'h20, 5'h00);
        @(posedge aclk) dest_addr <= 32'h00000100;
        ev(6'h20, 5'h10);
        w(`OOA_REG_OPTIONS, 32'h0);
        rd(`OOA_REG_ACTIVE, 32'h001A0140);
        w(`OOA_REG_CTRL, 32'h2);
        ev(6'h08, 5'h00);
        w(`OOA_REG_NODE_LO, 32'h40112233);
        w(`OOA_REG_NODE_HI, 32'h00004455);
        w(`OOA_REG_OPTIONS, 32'h0080);
        w(`OOA_REG_RXLIST, 32'h14);
        w(`OOA_REG_GROUP, 32'h0);
        w(`OOA_REG_FUNC, 32'h0);
        w(`OOA_REG_CTRL, 32'h1);
        rd(`OOA_REG_STATUS, 32'h1);
        chk(station_addr, 48'h401122334455);
        chk(rx_list_bytes, 16'h0014);
        ev(6'h01, 5'h01);
        ev(6'h04, 5'h02);
        ev(6'h10, 5'h00);
        @(posedge aclk) dest_addr <= 32'h0;
        ev(6'h20, 5'h00);
        give_verdict;
    end
endmodule
